// ===== cbf_pkg.sv
// Constants, register map and carrier types for the CAN timing and filter slice
package cbf_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_INT_EN      = 8'h00;
	localparam logic [7:0] OFF_ERR_CNT     = 8'h04;
	localparam logic [7:0] OFF_CFG_A       = 8'h08;
	localparam logic [7:0] OFF_CFG_B       = 8'h0C;
	localparam logic [7:0] OFF_FEN         = 8'h10;
	localparam logic [7:0] OFF_PTR0        = 8'h14;
	localparam logic [7:0] OFF_PTR3        = 8'h20;
	localparam logic [7:0] OFF_MSEL0       = 8'h24;
	localparam logic [7:0] OFF_MSEL1       = 8'h28;
	localparam logic [7:0] OFF_STATUS      = 8'h2C;
	localparam logic [7:0] OFF_MASK_BASE   = 8'h40;
	localparam logic [7:0] OFF_FILT_BASE   = 8'h80;

	// Writable bits of each register
	localparam logic [15:0] INT_EN_WMASK   = 16'h00EF;
	localparam logic [15:0] CFG_A_WMASK    = 16'h00FF;
	localparam logic [15:0] CFG_B_WMASK    = 16'h47FF;
	localparam logic [15:0] SID_WMASK      = 16'hFFEB;

	// Reset values
	localparam logic [15:0] FEN_RESET      = 16'h003F;

	// Field positions
	localparam int CFG_A_SJW_LSB   = 6;
	localparam int CFG_B_WAKFL_BIT = 14;
	localparam int CFG_B_PH2_LSB   = 8;
	localparam int CFG_B_PH2SEL    = 7;
	localparam int CFG_B_TRIPLE    = 6;
	localparam int CFG_B_PH1_LSB   = 3;
	localparam int SID_ID_LSB      = 5;
	localparam int SID_TYPE_BIT    = 3;

	// Mask select code meaning no mask
	localparam logic [1:0] MSEL_NONE = 2'b11;
	// Pointer code selecting the receive FIFO
	localparam logic [3:0] DEST_FIFO = 4'hF;

	// Fault confinement figures
	localparam logic [8:0] ERR_INC_BIG   = 9'h008;
	localparam logic [8:0] ERR_INC_SMALL = 9'h001;
	localparam logic [8:0] ERR_LIMIT     = 9'h0FF;
	localparam logic [7:0] REC_PASSIVE   = 8'h7F;
	localparam logic [7:0] REC_REJOIN    = 8'h77;
	localparam logic [7:0] ERR_WARN      = 8'h60;

	// Timing segments, Gray coded along the bit
	typedef enum logic [1:0] {
		CBF_SEG_SYNC = 2'b00,
		CBF_SEG_PROP = 2'b01,
		CBF_SEG_PH1  = 2'b11,
		CBF_SEG_PH2  = 2'b10
	} cbf_seg_t;

	// AHB-Lite request from the master
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} cbf_ahb_req_t;

	// Received frame identifier offered to the filters
	typedef struct packed {
		logic        valid;
		logic        extended;
		logic [10:0] sid;
		logic [17:0] eid;
	} cbf_frame_t;

	// Filter verdict
	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [3:0] filter;
		logic [3:0] dest;
		logic       to_fifo;
	} cbf_hit_t;

	// Fault confinement events from the protocol engine
	typedef struct packed {
		logic tx_err;
		logic tx_ok;
		logic rx_err;
		logic rx_err_big;
		logic rx_ok;
		logic recover;
	} cbf_err_evt_t;

endpackage

// ===== cbf_core.sv
// CAN bit timing, error counters, interrupt gating and acceptance filters
//
// What this block does
// - Each of seven interrupt flags reaches the interrupt only when its enable is set.
// - Transmit count in bits 15..8, receive count in 7..0, read only, zero at reset.
// - Jump width is the two-bit field plus one quanta.
// - One quantum is two times prescaler field plus one module clocks.
// - Wake-up detection uses the filtered line when selected, else the raw line.
// - Phase two length is its three-bit field plus one quanta.
// - Phase two select uses programmed length, else max of phase one and processing time.
// - Sampling select takes three samples at the sample point, else one.
// - Phase one length is bits 5..3 plus one quanta.
// - Propagation length is bits 2..0 plus one quanta.
// - Filter n accepts only while its enable is set; filters 0..5 enabled at reset.
// - A hit stores to the filter's pointer: buffers 0..14, or FIFO on code 15.
// - All unmasked standard identifier bits must equal filter bits 15..5.
// - Identifier mode set: frame type must match the filter's extended select.
// - Extended frames compare all eighteen unmasked extended identifier bits too.
// - Mask bit one compares that identifier bit, zero makes it don't-care.
// - Mask select codes pick mask 0, 1, 2; code 3 applies no mask.
`timescale 1ns/100ps
module cbf_core #(
	parameter int          IPT_TQ     = 2,
	parameter int          NUM_FILT   = 16,
	parameter logic [15:0] FEN_DEFAULT = cbf_pkg::FEN_RESET
) (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire cbf_pkg::cbf_ahb_req_t ahb_req,
	output      logic                  hreadyout,
	output      logic                  hresp,
	output      logic [31:0]           hrdata,
	// Bus line from the transceiver
	input  wire logic                  can_rx,
	// Module events
	input  wire logic [7:0]            irq_flags,
	input  wire cbf_pkg::cbf_err_evt_t err_evt,
	input  wire cbf_pkg::cbf_frame_t   frame_in,
	// Results
	output      logic                  irq,
	output      logic                  tq_tick,
	output      logic                  sample_point,
	output      logic                  rx_bit,
	output      logic                  wakeup,
	output      logic                  err_passive,
	output      logic                  err_warning,
	output      logic                  bus_off,
	output      cbf_pkg::cbf_hit_t     filt_result
);
	import cbf_pkg::*;

	// All state of the block
	typedef struct packed {
		logic [7:0]        int_en;
		logic [7:0]        tec;
		logic [7:0]        rec;
		logic              bus_off;
		logic [7:0]        cfg_a;
		logic [15:0]       cfg_b;
		logic [15:0]       fen;
		logic [15:0][3:0]  dptr;
		logic [15:0][1:0]  msel;
		logic [2:0][15:0]  msid;
		logic [2:0][15:0]  meid;
		logic [15:0][15:0] fsid;
		logic [15:0][15:0] feid;
		logic              dph_wr;
		logic [7:0]        dph_addr;
		logic [31:0]       rdata;
		logic              rx_s1;
		logic              rx_s2;
		logic [2:0]        lf_hist;
		logic              lf_line;
		logic              wk_prev;
		logic              wakeup;
		logic              rx_prev;
		logic [6:0]        pre_cnt;
		logic              tq_tick;
		cbf_seg_t          seg;
		logic [3:0]        tq_cnt;
		logic [2:0]        ph1_ext;
		logic              resynced;
		logic [1:0]        tq_hist;
		logic              rx_bit;
		logic              sample_pt;
		logic              irq;
		cbf_hit_t          res;
	} cbf_state_t;

	cbf_state_t st;
	cbf_state_t next_st;

	// Majority of three samples
	function automatic logic vote3(input logic a, input logic b, input logic c);
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction

	// Quanta of a segment whose field is length minus one
	function automatic logic [3:0] seg_len(input logic [2:0] fld);
		seg_len = {1'b0, fld} + 4'h1;
	endfunction

	// Nine-bit sum of an eight-bit counter and its increment; the caller saturates at the limit
	function automatic logic [8:0] err_add(input logic [7:0] cnt, input logic [8:0] inc);
		err_add = {1'b0, cnt} + inc;
	endfunction

	// Acceptance test of one filter against the offered frame
	function automatic logic filt_match(input cbf_state_t s, input cbf_frame_t f,
			input int n);
		logic [15:0] ms;
		logic [15:0] me;
		logic        mode;
		logic        sid_ok;
		logic        eid_ok;
		logic        type_ok;
		ms = '1;
		me = '1;
		mode = 1'b1;
		if (s.msel[n] != MSEL_NONE) begin
			ms = s.msid[s.msel[n]];
			me = s.meid[s.msel[n]];
			mode = s.msid[s.msel[n]][SID_TYPE_BIT];
		end
		// A one in the mask compares the bit, a zero ignores it
		sid_ok = &(~(f.sid ^ s.fsid[n][15:SID_ID_LSB]) | ~ms[15:SID_ID_LSB]);
		eid_ok = &(~(f.eid ^ {s.fsid[n][1:0], s.feid[n]}) | ~{ms[1:0], me});
		type_ok = !mode || (f.extended == s.fsid[n][SID_TYPE_BIT]);
		filt_match = s.fen[n] && type_ok && sid_ok && (!f.extended || eid_ok);
	endfunction

	// Register read mux
	function automatic logic [15:0] rd_reg(input cbf_state_t s, input logic [7:0] a);
		rd_reg = '0;
		if (a[7]) begin
			rd_reg = a[2] ? s.feid[a[6:3]] : (s.fsid[a[6:3]] & SID_WMASK);
		end else if (a[7:5] == OFF_MASK_BASE[7:5]) begin
			if (a[4:3] != 2'b11) begin
				rd_reg = a[2] ? s.meid[a[4:3]] : (s.msid[a[4:3]] & SID_WMASK);
			end
		end else if (a >= OFF_PTR0 && a <= OFF_PTR3 && a[1:0] == 2'b00) begin
			rd_reg = s.dptr[(a - OFF_PTR0) >> 2 << 2 +: 4];
		end else begin
			unique case (a)
				OFF_INT_EN:  rd_reg = {8'h00, s.int_en};
				OFF_ERR_CNT: rd_reg = {s.tec, s.rec};
				OFF_CFG_A:   rd_reg = {8'h00, s.cfg_a};
				OFF_CFG_B:   rd_reg = s.cfg_b;
				OFF_FEN:     rd_reg = s.fen;
				OFF_MSEL0:   rd_reg = s.msel[7:0];
				OFF_MSEL1:   rd_reg = s.msel[15:8];
				OFF_STATUS:  rd_reg = {12'h000, s.bus_off, s.rx_bit, s.seg};
				default:     rd_reg = '0;
			endcase
		end
	endfunction

	// Next state of the whole block
	always_comb begin
		logic        acc;
		logic [15:0] wd;
		logic [7:0]  wa;
		logic [6:0]  pre_lim;
		logic [3:0]  ph1_q;
		logic [3:0]  ph2_q;
		logic [3:0]  prop_q;
		logic [3:0]  sjw_q;
		logic        wk_line;
		logic        edge_seen;
		logic [8:0]  sum;
		ph2_q = '0;
		sum = '0;
		next_st = st;
		acc = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
		wd = ahb_req.hwdata[15:0];
		wa = st.dph_addr;

		// Data phase of a write lands in the addressed register
		if (st.dph_wr) begin
			if (wa[7]) begin
				if (wa[2]) begin
					next_st.feid[wa[6:3]] = wd;
				end else begin
					next_st.fsid[wa[6:3]] = wd & SID_WMASK;
				end
			end else if (wa[7:5] == OFF_MASK_BASE[7:5]) begin
				if (wa[4:3] != 2'b11) begin
					if (wa[2]) begin
						next_st.meid[wa[4:3]] = wd;
					end else begin
						next_st.msid[wa[4:3]] = wd & SID_WMASK;
					end
				end
			end else if (wa >= OFF_PTR0 && wa <= OFF_PTR3 && wa[1:0] == 2'b00) begin
				next_st.dptr[(wa - OFF_PTR0) >> 2 << 2 +: 4] = wd;
			end else begin
				unique case (wa)
					OFF_INT_EN: next_st.int_en = wd[7:0] & INT_EN_WMASK[7:0];
					OFF_CFG_A:  next_st.cfg_a = wd[7:0] & CFG_A_WMASK[7:0];
					OFF_CFG_B:  next_st.cfg_b = wd & CFG_B_WMASK;
					OFF_FEN:    next_st.fen = wd;
					OFF_MSEL0:  next_st.msel[7:0] = wd;
					OFF_MSEL1:  next_st.msel[15:8] = wd;
					default:    next_st.dph_wr = 1'b0;
				endcase
			end
		end

		// Address phase; read data built from the updated copy so a read
		// straight after a write sees the new value
		next_st.dph_wr = acc && ahb_req.hwrite;
		next_st.dph_addr = ahb_req.haddr[7:0];
		if (acc && !ahb_req.hwrite) begin
			next_st.rdata = {16'h0000, rd_reg(next_st, ahb_req.haddr[7:0])};
		end

		// Interrupt gating
		next_st.irq = |(irq_flags & st.int_en & INT_EN_WMASK[7:0]);

		// Fault confinement, counters saturate at the eight-bit limit
		if (err_evt.recover) begin
			next_st.tec = '0;
			next_st.rec = '0;
			next_st.bus_off = 1'b0;
		end else begin
			if (err_evt.tx_err) begin
				sum = err_add(st.tec, ERR_INC_BIG);
				next_st.tec = (sum > ERR_LIMIT) ? ERR_LIMIT[7:0] : sum[7:0];
				next_st.bus_off = st.bus_off | (sum > ERR_LIMIT);
			end else if (err_evt.tx_ok && st.tec != '0) begin
				next_st.tec = st.tec - 8'h01;
			end
			if (err_evt.rx_err || err_evt.rx_err_big) begin
				sum = err_add(st.rec, err_evt.rx_err_big ? ERR_INC_BIG : ERR_INC_SMALL);
				next_st.rec = (sum > ERR_LIMIT) ? ERR_LIMIT[7:0] : sum[7:0];
			end else if (err_evt.rx_ok) begin
				if (st.rec > REC_PASSIVE) begin
					next_st.rec = REC_REJOIN;
				end else if (st.rec != '0) begin
					next_st.rec = st.rec - 8'h01;
				end
			end
		end

		// Pin synchroniser and three-sample line filter
		next_st.rx_s1 = can_rx;
		next_st.rx_s2 = st.rx_s1;
		next_st.lf_hist = {st.lf_hist[1:0], st.rx_s2};
		if (&st.lf_hist) begin
			next_st.lf_line = 1'b1;
		end else if (~|st.lf_hist) begin
			next_st.lf_line = 1'b0;
		end

		// Wake-up on a dominant edge of the chosen line
		wk_line = st.cfg_b[CFG_B_WAKFL_BIT] ? st.lf_line : st.rx_s2;
		next_st.wk_prev = wk_line;
		next_st.wakeup = st.wk_prev && !wk_line;

		// Quantum prescaler, 2*(field+1) clocks per quantum
		pre_lim = {st.cfg_a[5:0], 1'b1};
		next_st.tq_tick = 1'b0;
		if (st.pre_cnt >= pre_lim) begin
			next_st.pre_cnt = '0;
			next_st.tq_tick = 1'b1;
		end else begin
			next_st.pre_cnt = st.pre_cnt + 7'h01;
		end

		// Segment lengths in quanta
		sjw_q = {2'b00, st.cfg_a[7:CFG_A_SJW_LSB]} + 4'h1;
		prop_q = seg_len(st.cfg_b[2:0]);
		ph1_q = seg_len(st.cfg_b[CFG_B_PH1_LSB +: 3]);
		if (st.cfg_b[CFG_B_PH2SEL]) begin
			ph2_q = seg_len(st.cfg_b[CFG_B_PH2_LSB +: 3]);
		end else begin
			ph2_q = (ph1_q > 4'(IPT_TQ)) ? ph1_q : 4'(IPT_TQ);
		end

		// Recessive to dominant edge, one resynchronisation per bit
		next_st.rx_prev = st.rx_s2;
		edge_seen = st.rx_prev && !st.rx_s2 && !st.resynced;
		next_st.sample_pt = 1'b0;

		if (edge_seen && st.seg == CBF_SEG_PH2 && (ph2_q - st.tq_cnt) <= sjw_q) begin
			// Late in phase two: shorten, the edge opens the next bit
			next_st.seg = CBF_SEG_PROP;
			next_st.tq_cnt = '0;
			next_st.pre_cnt = '0;
			next_st.ph1_ext = '0;
			next_st.resynced = 1'b1;
		end else begin
			if (edge_seen && (st.seg == CBF_SEG_PROP || st.seg == CBF_SEG_PH1)) begin
				next_st.ph1_ext = sjw_q[2:0] + 3'(sjw_q[3]);
				next_st.resynced = 1'b1;
			end
			if (st.tq_tick) begin
				next_st.tq_hist = {st.tq_hist[0], st.rx_s2};
				next_st.tq_cnt = st.tq_cnt + 4'h1;
				unique case (st.seg)
					CBF_SEG_SYNC: begin
						next_st.seg = CBF_SEG_PROP;
						next_st.tq_cnt = '0;
						next_st.resynced = 1'b0;
					end
					CBF_SEG_PROP: begin
						if (st.tq_cnt == prop_q - 4'h1) begin
							next_st.seg = CBF_SEG_PH1;
							next_st.tq_cnt = '0;
						end
					end
					CBF_SEG_PH1: begin
						if (st.tq_cnt >= ph1_q + {1'b0, st.ph1_ext} - 4'h1) begin
							next_st.seg = CBF_SEG_PH2;
							next_st.tq_cnt = '0;
							next_st.ph1_ext = '0;
							next_st.sample_pt = 1'b1;
							if (st.cfg_b[CFG_B_TRIPLE]) begin
								next_st.rx_bit = vote3(st.tq_hist[1], st.tq_hist[0],
									st.rx_s2);
							end else begin
								next_st.rx_bit = st.rx_s2;
							end
						end
					end
					CBF_SEG_PH2: begin
						if (st.tq_cnt >= ph2_q - 4'h1) begin
							next_st.seg = CBF_SEG_SYNC;
							next_st.tq_cnt = '0;
						end
					end
				endcase
			end
		end

		// Acceptance filters, lowest numbered hit wins
		next_st.res.valid = frame_in.valid;
		if (frame_in.valid) begin
			next_st.res.hit = 1'b0;
			next_st.res.filter = '0;
			next_st.res.dest = '0;
			next_st.res.to_fifo = 1'b0;
			for (int n = NUM_FILT - 1; n >= 0; n--) begin
				if (filt_match(st, frame_in, n)) begin
					next_st.res.hit = 1'b1;
					next_st.res.filter = 4'(n);
					next_st.res.dest = st.dptr[n];
					next_st.res.to_fifo = (st.dptr[n] == DEST_FIFO);
				end
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.fen <= FEN_DEFAULT;
			st.rx_s1 <= 1'b1;
			st.rx_s2 <= 1'b1;
			st.lf_hist <= '1;
			st.lf_line <= 1'b1;
			st.wk_prev <= 1'b1;
			st.rx_prev <= 1'b1;
			st.rx_bit <= 1'b1;
			st.seg <= CBF_SEG_SYNC;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign irq = st.irq;
	assign tq_tick = st.tq_tick;
	assign sample_point = st.sample_pt;
	assign rx_bit = st.rx_bit;
	assign wakeup = st.wakeup;
	assign err_passive = (st.tec > REC_PASSIVE) || (st.rec > REC_PASSIVE);
	assign err_warning = (st.tec >= ERR_WARN) || (st.rec >= ERR_WARN);
	assign bus_off = st.bus_off;
	assign filt_result = st.res;

endmodule

// ===== cbf_chk.sv
// Port assertions for the CAN timing and filter slice
`timescale 1ns/100ps
module cbf_chk (
	// Clock and reset
	input wire logic                  hclk,
	input wire logic                  hresetn,
	// Bus answer
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	// Events in
	input wire logic [7:0]            irq_flags,
	input wire cbf_pkg::cbf_err_evt_t err_evt,
	input wire cbf_pkg::cbf_frame_t   frame_in,
	// Results
	input wire logic                  irq,
	input wire logic                  tq_tick,
	input wire logic                  sample_point,
	input wire logic                  wakeup,
	input wire logic                  err_passive,
	input wire logic                  err_warning,
	input wire logic                  bus_off,
	input wire cbf_pkg::cbf_hit_t     filt_result
);
	import cbf_pkg::*;

	// One clock domain throughout
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Shortest bit is four quanta of two clocks
	sequence s_quiet_sp;
		!sample_point [*7];
	endsequence

	// Bus slave never stalls or errors
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_irq_gated: assert property (irq_flags == 8'h00 |=> !irq)
		else $error("interrupt without any flag");
	a_filt_latency: assert property (frame_in.valid |=> filt_result.valid)
		else $error("filter verdict missing");
	a_filt_spur: assert property (!frame_in.valid |=> !filt_result.valid)
		else $error("filter verdict without frame");
	a_fifo_code: assert property (filt_result.valid && filt_result.hit |->
		filt_result.to_fifo == (filt_result.dest == DEST_FIFO))
		else $error("fifo flag disagrees with pointer");
	a_quantum_min: assert property (tq_tick |=> !tq_tick)
		else $error("quantum shorter than two clocks");
	a_sample_tick: assert property (sample_point |-> $past(tq_tick))
		else $error("sample point off a quantum edge");
	a_bit_min: assert property (sample_point |=> s_quiet_sp)
		else $error("bit shorter than four quanta");
	a_wake_pulse: assert property (wakeup |=> !wakeup)
		else $error("wake-up longer than one clock");
	a_passive_warn: assert property (err_passive |-> err_warning)
		else $error("passive without warning");
	a_busoff_clear: assert property (err_evt.recover |=> !bus_off)
		else $error("bus off survived recovery");
endmodule

bind cbf_core cbf_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp, .irq_flags, .err_evt,
	.frame_in, .irq, .tq_tick, .sample_point, .wakeup, .err_passive, .err_warning,
	.bus_off, .filt_result);

// ===== cbf_bus_model.sv
// Bus line as the transceiver presents it, recessive when idle
`timescale 1ns/100ps
module cbf_bus_model (
	// Clock
	input  wire logic hclk,
	// Line to the controller
	output      logic can_rx
);
	// With nobody dominant the bus rests recessive
	initial can_rx = 1'b1;

	// Pull the line dominant for n clocks, then let it go
	task automatic dominant(input int n);
		@(posedge hclk);
		can_rx <= 1'b0;
		repeat (n) @(posedge hclk);
		can_rx <= 1'b1;
	endtask

	// Settle on a level until told otherwise
	task automatic level(input logic v);
		@(posedge hclk);
		can_rx <= v;
	endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the CAN timing and filter slice
`timescale 1ns/100ps
module tb_top;
	import cbf_pkg::*;
	localparam int IPT = 2;
	logic         hclk = 1'b0;
	logic         hresetn = 1'b0;
	cbf_ahb_req_t rq = '0;
	logic         hreadyout, hresp, can_rx, irq, tq_tick, sample_point;
	logic         rx_bit, wakeup, err_passive, err_warning, bus_off, wk;
	logic [31:0]  hrdata;
	logic [7:0]   irq_flags = '0;
	cbf_err_evt_t err_evt = '0;
	cbf_frame_t   frame_in = '0;
	cbf_hit_t     filt_result;
	int           num_errors = 0;
	int           n_compared = 0;
	int           rows[4][7];
	int           n, ph2;

	// 100 MHz clock
	always #5 hclk = ~hclk;

	cbf_core #(.IPT_TQ(IPT)) i_cbf_core (
		.hclk, .hresetn, .hreadyout, .hresp, .hrdata, .can_rx, .irq_flags, .err_evt,
		.frame_in, .irq, .tq_tick, .sample_point, .rx_bit, .wakeup, .err_passive,
		.err_warning, .bus_off, .filt_result,
		.ahb_req({rq.hsel, rq.haddr, rq.htrans, rq.hwrite, rq.hsize, rq.hwdata, hreadyout})
	);
	cbf_bus_model i_cbf_bus_model (.hclk, .can_rx);

	// Compare and count
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic test_done;
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Wait for hready under a bound
	task automatic await_rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			test_done;
		end
	endtask

	// One single word transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		rq.hsel <= 1'b1;
		rq.htrans <= 2'b10;
		rq.haddr <= {24'h0, a};
		rq.hwrite <= w;
		rq.hsize <= 3'b010;
		await_rdy;
		rq.hsel <= 1'b0;
		rq.htrans <= 2'b00;
		rq.hwdata <= {16'h0, d};
		await_rdy;
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 16'h0000, q);
		check($sformatf("register %h", a), q, {16'h0, e});
	endtask

	// Clocks from one pulse to the next, of sample points or quanta
	task automatic span(input logic sp, output int c);
		int k;
		k = 0;
		while ((sp ? sample_point : tq_tick) !== 1'b1 && k < 4000) begin
			@(negedge hclk);
			k++;
		end
		c = 0;
		do begin
			@(negedge hclk);
			c++;
		end while ((sp ? sample_point : tq_tick) !== 1'b1 && c < 4000);
		if (k >= 4000 || c >= 4000) begin
			num_errors++;
			test_done;
		end
	endtask

	// One-clock event pulse
	task automatic ev(input cbf_err_evt_t e);
		@(posedge hclk);
		err_evt <= e;
		@(posedge hclk);
		err_evt <= '0;
		@(negedge hclk);
	endtask

	// Offer a frame and judge the verdict
	task automatic fr(input logic x, input logic [10:0] s, input logic [17:0] e,
			input logic h, input logic [3:0] f, input logic [3:0] dst);
		@(posedge hclk);
		frame_in <= {1'b1, x, s, e};
		@(posedge hclk);
		frame_in.valid <= 1'b0;
		@(negedge hclk);
		check("filter valid", filt_result.valid, 1'b1);
		check("filter hit", filt_result.hit, h);
		if (h)
			check("filter target", {filt_result.filter, filt_result.dest, filt_result.to_fifo},
				{f, dst, dst == DEST_FIFO});
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(OFF_FEN, 16'h003F);
		rdc(OFF_INT_EN, 16'h0000);
		wr(OFF_ERR_CNT, 16'hFFFF);
		rdc(OFF_ERR_CNT, 16'h0000);
		rdc(8'h3C, 16'h0000);
		wr(OFF_CFG_B, 16'hFFFF);
		rdc(OFF_CFG_B, 16'h47FF);
		wr(OFF_INT_EN, 16'hFFFF);
		rdc(OFF_INT_EN, 16'h00EF);
		for (int b = 0; b < 8; b++) begin
			wr(OFF_INT_EN, 16'h0001 << b);
			irq_flags <= ~(8'h01 << b);
			repeat (3) @(posedge hclk);
			check("irq masked", irq, 1'b0);
			irq_flags <= 8'h01 << b;
			repeat (3) @(posedge hclk);
			check("irq enabled", irq, b != 4);
		end
		irq_flags <= 8'h00;
		// Prescaler, jump width, prop, ph1, ph2, ph2 select, triple sample
		rows = '{'{0, 0, 0, 0, 1, 1, 0}, '{63, 3, 7, 7, 7, 1, 0},
			'{1, 1, 2, 4, 0, 0, 0}, '{2, 0, 1, 0, 0, 0, 1}};
		foreach (rows[r]) begin
			wr(OFF_CFG_A, 16'(rows[r][1] * 64 + rows[r][0]));
			wr(OFF_CFG_B, 16'(rows[r][4] * 256 + rows[r][5] * 128 + rows[r][6] * 64
				+ rows[r][3] * 8 + rows[r][2]));
			rdc(OFF_CFG_A, 16'(rows[r][1] * 64 + rows[r][0]));
			repeat (2) span(1'b0, n);
			check("quantum clocks", n, 2 * (rows[r][0] + 1));
			repeat (3) span(1'b1, n);
			ph2 = rows[r][5] ? rows[r][4] + 1 : (rows[r][3] + 1 > IPT ? rows[r][3] + 1 : IPT);
			ph2 = 2 * (rows[r][0] + 1) * (3 + rows[r][2] + rows[r][3] + ph2);
			check("bit clocks", n, ph2);
		end
		i_cbf_bus_model.level(1'b0);
		repeat (60) @(posedge hclk);
		check("rx bit", rx_bit, 1'b0);
		i_cbf_bus_model.level(1'b1);
		repeat (60) @(posedge hclk);
		check("rx bit", rx_bit, 1'b1);
		for (int f = 0; f < 2; f++) begin
			wr(OFF_CFG_B, 16'(f * 16384));
			i_cbf_bus_model.dominant(1);
			wk = 1'b0;
			repeat (10) @(negedge hclk) wk |= wakeup;
			check("wake on glitch", wk, f == 0);
		end
		i_cbf_bus_model.level(1'b0);
		wk = 1'b0;
		repeat (12) @(negedge hclk) wk |= wakeup;
		check("wake filtered", wk, 1'b1);
		i_cbf_bus_model.level(1'b1);
		ev(6'h20);
		rdc(OFF_ERR_CNT, 16'h0800);
		ev(6'h08);
		ev(6'h04);
		rdc(OFF_ERR_CNT, 16'h0809);
		ev(6'h02);
		ev(6'h10);
		rdc(OFF_ERR_CNT, 16'h0708);
		for (int i = 1; i <= 32; i++) begin
			ev(6'h20);
			if (i == 13)
				check("warn passive", {err_warning, err_passive}, 2'b10);
		end
		check("bus off", bus_off, 1'b1);
		check("error passive", err_passive, 1'b1);
		ev(6'h01);
		check("bus off", bus_off, 1'b0);
		fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h0, 4'h0);
		wr(OFF_MASK_BASE, 16'hFFE0);
		fr(1'b0, 11'h123, 18'h0, 1'b0, 4'h0, 4'h0);
		wr(OFF_FILT_BASE + 8'h10, 16'h2460);
		wr(OFF_PTR0, 16'h0F00);
		fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h2, 4'hF);
		wr(OFF_PTR0, 16'h0E00);
		fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h2, 4'hE);
		wr(OFF_FEN, 16'h003B);
		fr(1'b0, 11'h123, 18'h0, 1'b0, 4'h0, 4'h0);
		wr(OFF_FEN, 16'h003F);
		wr(OFF_MASK_BASE, 16'hFFE8);
		fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h2, 4'hE);
		fr(1'b1, 11'h123, 18'h0, 1'b0, 4'h0, 4'h0);
		wr(OFF_MASK_BASE, 16'hFFE3);
		wr(OFF_MASK_BASE + 8'h04, 16'hFFFF);
		wr(OFF_FILT_BASE + 8'h10, 16'h2462);
		wr(OFF_FILT_BASE + 8'h14, 16'hABCD);
		fr(1'b1, 11'h123, 18'h2ABCD, 1'b1, 4'h2, 4'hE);
		fr(1'b1, 11'h123, 18'h2ABCC, 1'b0, 4'h0, 4'h0);
		fr(1'b1, 11'h123, 18'h1ABCD, 1'b0, 4'h0, 4'h0);
		for (int c = 0; c < 4; c++) begin
			wr(OFF_MSEL0, 16'(c * 16));
			fr(1'b1, 11'h7FF, 18'h0, c == 1 || c == 2, 4'h2, 4'hE);
		end
		fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h2, 4'hE);
		test_done;
	end
endmodule
